// [mslu_pkg.sv]
// Shared encodings and constants for the MAC and SIMD lane unit
package mslu_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OPC_LSB     = 0;
  localparam int F3_LSB      = 12;
  localparam int SHAMT_LSB   = 25;
  localparam int VARIANT_LSB = 30;
  localparam int F7_LSB      = 25;

  // ----------------------------------------------------------------
  // Opcode and function codes
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_HALF    = 7'h5b;
  localparam logic [6:0] OPC_FULL    = 7'h2b;
  localparam logic [2:0] F3_MUL_U    = 3'h5;
  localparam logic [2:0] F3_MUL_S    = 3'h4;
  localparam logic [2:0] F3_MAC_U    = 3'h7;
  localparam logic [2:0] F3_MAC_S    = 3'h6;
  localparam logic [2:0] F3_FULL     = 3'h3;
  localparam logic [6:0] F7_FULL_ACC = 7'h48;
  localparam logic [6:0] F7_FULL_SUB = 7'h49;

  // Variant field: bit 0 picks high halves, bit 1 picks rounding
  localparam int VAR_HIGH_BIT  = 0;
  localparam int VAR_ROUND_BIT = 1;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          XLEN       = 32;
  localparam int          HALF_W     = 16;
  localparam int          BYTE_W     = 8;
  localparam int          IMM_W      = 6;
  localparam logic [31:0] RESULT_RST = 32'h0;

  // Second operand source for packed operations
  typedef enum logic [1:0] {
    MSLU_VECTOR,
    MSLU_SCALAR,
    MSLU_IMMEDIATE
  } mslu_mode_t;

endpackage

// [mslu_half_mac.sv]
// Half-word multiply, optional accumulate, rounding and right shift
`timescale 1ns/1ps
module mslu_half_mac
  import mslu_pkg::*;
(
  // Operands
  input  wire logic [31:0] srcA,
  input  wire logic [31:0] srcB,
  input  wire logic [31:0] accIn,
  // Form selection
  input  wire logic        highHalf,
  input  wire logic        signedOp,
  input  wire logic        roundOn,
  input  wire logic        accumulate,
  input  wire logic [4:0]  shamt,
  // Result
  output logic      [31:0] result
);

  wire logic [15:0]        halfA = highHalf ? srcA[31:16] : srcA[15:0];
  wire logic [15:0]        halfB = highHalf ? srcB[31:16] : srcB[15:0];
  wire logic signed [17:0] extA  = {{2{signedOp & halfA[15]}}, halfA};
  wire logic signed [17:0] extB  = {{2{signedOp & halfB[15]}}, halfB};
  wire logic signed [35:0] prod  = extA * extB;
  wire logic [33:0]        accExt;
  wire logic [33:0]        roundTerm;
  wire logic [33:0]        sum;
  wire logic [33:0]        shifted;

  // Old destination joins only the accumulate forms
  assign accExt = accumulate ? {{2{signedOp & accIn[31]}}, accIn} : 34'h0;
  // Rounding adds half of the discarded weight, nothing at shift zero
  // rounding term
  assign roundTerm = (roundOn && shamt != 5'h0) ? (34'h1 << (shamt - 5'h1)) : 34'h0;
  assign sum       = prod[33:0] + accExt + roundTerm;
  assign shifted   = signedOp ? 34'($signed(sum) >>> shamt) : (sum >> shamt);
  assign result    = shifted[31:0];

endmodule

// [mslu_simd_lanes.sv]
// Packed lane operand builder and wrap-around lane adder
`timescale 1ns/1ps
module mslu_simd_lanes
  import mslu_pkg::*;
(
  // Operands
  input  wire logic [31:0] srcA,
  input  wire logic [31:0] srcB,
  input  wire logic [5:0]  imm,
  // Control
  input  wire logic        halfLanes,
  input  wire mslu_mode_t  mode,
  input  wire logic        immUnsigned,
  input  wire logic        subtract,
  // Result
  output logic      [31:0] result
);

  wire logic [15:0] immExt;
  wire logic [31:0] scalarRep;
  wire logic [31:0] immRep;
  wire logic [31:0] op2;
  wire logic [31:0] halfRes;
  wire logic [31:0] byteRes;

  assign immExt    = immUnsigned ? {10'h0, imm} : {{10{imm[5]}}, imm};
  assign scalarRep = halfLanes ? {2{srcB[15:0]}} : {4{srcB[7:0]}};
  assign immRep    = halfLanes ? {2{immExt}} : {4{immExt[7:0]}};
  assign op2 = (mode == MSLU_SCALAR)    ? scalarRep :
               (mode == MSLU_IMMEDIATE) ? immRep    : srcB;

  // Each lane sum is cut to lane width, carries never cross
  genvar h;
  generate
    for (h = 0; h < 2; h++)
    begin : g_half
      wire logic [15:0] a = srcA[h*16 +: 16];
      wire logic [15:0] b = op2[h*16 +: 16];
      assign halfRes[h*16 +: 16] = subtract ? 16'(a - b) : 16'(a + b);
    end
    for (h = 0; h < 4; h++)
    begin : g_byte
      wire logic [7:0] a = srcA[h*8 +: 8];
      wire logic [7:0] b = op2[h*8 +: 8];
      assign byteRes[h*8 +: 8] = subtract ? 8'(a - b) : 8'(a + b);
    end
  endgenerate

  assign result = halfLanes ? halfRes : byteRes;

endmodule

// [mslu_unit.sv]
// MAC and packed-lane execution unit with registered result
//
// Operation
// - unsigned low mac, logical shift
// - unsigned high mac, logical shift
// - signed low mac, arithmetic shift
// - signed high mac, arithmetic shift
// - rounding adds half of shift weight
// - shift zero means no rounding term
// - full width add or subtract product
// - multiply group decode, shift field
// - variant field picks half and rounding
// - accumulate group decode on same opcode
// - full width accumulate decode
// - four byte or two halfword lanes
// - lanes wrap, no carry flags
// - vector mode pairs matching lanes
// - scalar mode replicates low lane
// - immediate mode replicates extended immediate
// - immediate signed except shuffle ops
// - fixed lane bit positions
// - packed ops need extension enabled
// - mac ops need extension enabled
// - multiply forms skip destination add
`timescale 1ns/1ps
module mslu_unit
  import mslu_pkg::*;
#(
  parameter bit CUSTOM_EXT_ENABLE = 1'b1
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Issue from decode
  input  wire logic        issueValid,
  input  wire logic [31:0] instr,
  input  wire logic        packedOp,
  // Packed operation controls
  input  wire logic        packedHalf,
  input  wire mslu_mode_t  packedMode,
  input  wire logic [5:0]  packedImm,
  input  wire logic        packedImmUnsigned,
  input  wire logic        packedSub,
  // Register file operands
  input  wire logic [31:0] srcA,
  input  wire logic [31:0] srcB,
  input  wire logic [31:0] srcDest,
  // Result to writeback
  output logic             resultValid,
  output logic      [31:0] resultData,
  output logic             resultUnknown
);

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire logic [6:0] opcode  = instr[OPC_LSB +: 7];
  wire logic [2:0] funct3  = instr[F3_LSB +: 3];
  wire logic [6:0] funct7  = instr[F7_LSB +: 7];
  wire logic [1:0] variant = instr[VARIANT_LSB +: 2];
  wire logic [4:0] shamt   = instr[SHAMT_LSB +: 5];

  wire logic extOn = CUSTOM_EXT_ENABLE;
  wire logic halfGroup;
  wire logic isMulU;
  wire logic isMulS;
  wire logic isMacU;
  wire logic isMacS;
  wire logic isHalfOp;
  wire logic isFullAcc;
  wire logic isFullSub;
  wire logic isPacked;
  wire logic known;

  assign halfGroup = extOn && !packedOp && opcode == OPC_HALF;
  assign isMulU    = halfGroup && funct3 == F3_MUL_U;
  assign isMulS    = halfGroup && funct3 == F3_MUL_S;
  assign isMacU    = halfGroup && funct3 == F3_MAC_U;
  assign isMacS    = halfGroup && funct3 == F3_MAC_S;
  assign isHalfOp  = isMulU || isMulS || isMacU || isMacS;
  assign isFullAcc = extOn && !packedOp && opcode == OPC_FULL && funct3 == F3_FULL
                     && funct7 == F7_FULL_ACC;
  assign isFullSub = extOn && !packedOp && opcode == OPC_FULL && funct3 == F3_FULL
                     && funct7 == F7_FULL_SUB;
  assign isPacked  = extOn && packedOp;
  assign known     = isHalfOp || isFullAcc || isFullSub || isPacked;

  // ----------------------------------------------------------------
  // Half-word multiply and accumulate
  // ----------------------------------------------------------------
  wire logic [31:0] halfResult;
  wire logic        halfSigned;
  wire logic        halfAccum;

  assign halfSigned = isMulS || isMacS;
  assign halfAccum  = isMacU || isMacS;

  mslu_half_mac u_half_mac (
    .srcA       (srcA),
    .srcB       (srcB),
    .accIn      (srcDest),
    .highHalf   (variant[VAR_HIGH_BIT]),
    .signedOp   (halfSigned),
    .roundOn    (variant[VAR_ROUND_BIT]),
    .accumulate (halfAccum),
    .shamt      (shamt),
    .result     (halfResult)
  );

  // ----------------------------------------------------------------
  // Full width accumulate
  // ----------------------------------------------------------------
  wire logic [63:0] fullProd = srcA * srcB;
  wire logic [31:0] fullResult;

  // low 32 bits of exact result
  assign fullResult = isFullSub ? 32'(srcDest - fullProd[31:0])
                                : 32'(srcDest + fullProd[31:0]);

  // ----------------------------------------------------------------
  // Packed lanes
  // ----------------------------------------------------------------
  wire logic [31:0] packedResult;

  mslu_simd_lanes u_simd_lanes (
    .srcA        (srcA),
    .srcB        (srcB),
    .imm         (packedImm),
    .halfLanes   (packedHalf),
    .mode        (packedMode),
    .immUnsigned (packedImmUnsigned),
    .subtract    (packedSub),
    .result      (packedResult)
  );

  // ----------------------------------------------------------------
  // Result selection and register
  // ----------------------------------------------------------------
  wire logic [31:0] next_resultData;

  assign next_resultData = isPacked                ? packedResult :
                           (isFullAcc || isFullSub) ? fullResult  :
                           isHalfOp                 ? halfResult  : RESULT_RST;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resultValid   <= 1'b0;
      resultData    <= RESULT_RST;
      resultUnknown <= 1'b0;
    end
    else
    begin
      resultValid   <= issueValid && known;
      resultUnknown <= issueValid && !known;
      if (issueValid)
      begin
        resultData <= next_resultData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence fullAccIssue;
    issueValid && isFullAcc;
  endsequence

  sequence fullSubIssue;
    issueValid && isFullSub;
  endsequence

  sequence mulULowIssue;
    issueValid && isMulU && variant == 2'h0;
  endsequence

  sequence resultOut;
    resultValid && !resultUnknown;
  endsequence

  sequence macULowIssue;
    issueValid && isMacU && variant == 2'h0;
  endsequence

  sequence macUHighIssue;
    issueValid && isMacU && variant == 2'h1;
  endsequence

  sequence macSLowIssue;
    issueValid && isMacS && variant == 2'h0;
  endsequence

  sequence macSHighIssue;
    issueValid && isMacS && variant == 2'h1;
  endsequence

  sequence refusedIssue;
    issueValid && !known;
  endsequence

  sequence unknownOut;
    resultUnknown && !resultValid && resultData == RESULT_RST;
  endsequence

  wire logic [31:0]        refMulULow = 32'(srcA[15:0]) * 32'(srcB[15:0]);
  wire logic [31:0]        refMacULow = 32'(refMulULow + srcDest);
  wire logic [31:0]        refFull    = 32'(srcA * srcB);
  wire logic [15:0]        refImmHalf = {{10{packedImm[5]}}, packedImm};
  wire logic signed [15:0] lowA       = srcA[15:0];
  wire logic signed [15:0] lowB       = srcB[15:0];
  wire logic signed [15:0] highA      = srcA[31:16];
  wire logic signed [15:0] highB      = srcB[31:16];
  wire logic [33:0]        refMacUL   = 34'(srcA[15:0]) * 34'(srcB[15:0]) + 34'(srcDest);
  wire logic [33:0]        refMacUH   = 34'(srcA[31:16]) * 34'(srcB[31:16]) + 34'(srcDest);
  wire logic signed [33:0] refMacSL   = lowA * lowB + $signed(srcDest);
  wire logic signed [33:0] refMacSH   = highA * highB + $signed(srcDest);
  wire logic signed [33:0] refMulSH   = highA * highB;

  full_acc_a: assert property (
    fullAccIssue |=> resultOut ##0 resultData == 32'($past(srcDest) + $past(refFull)))
    else $error("full accumulate result wrong");

  full_sub_a: assert property (
    fullSubIssue |=> resultOut ##0 resultData == 32'($past(srcDest) - $past(refFull)))
    else $error("full subtract result wrong");

  mul_no_acc_a: assert property (
    mulULowIssue |=> resultData == ($past(refMulULow) >> $past(shamt)))
    else $error("multiply form added destination");

  round_zero_a: assert property (
    issueValid && isMulU && variant == 2'h2 && shamt == 5'h0
    |=> resultData == $past(refMulULow))
    else $error("rounding term added at zero shift");

  mac_low_a: assert property (
    issueValid && isMacU && variant == 2'h0 && shamt == 5'h0
    |=> resultData == $past(refMacULow))
    else $error("unsigned low accumulate wrong");

  lane_wrap_a: assert property (
    issueValid && isPacked && packedHalf && packedMode == MSLU_VECTOR && !packedSub
    |=> resultData[15:0] == 16'($past(srcA[15:0]) + $past(srcB[15:0]))
        && resultData[31:16] == 16'($past(srcA[31:16]) + $past(srcB[31:16])))
    else $error("halfword lane sum wrong");

  scalar_rep_a: assert property (
    issueValid && isPacked && !packedHalf && packedMode == MSLU_SCALAR && !packedSub
    |=> resultData[31:24] == 8'($past(srcA[31:24]) + $past(srcB[7:0])))
    else $error("scalar lane not replicated");

  imm_sign_a: assert property (
    issueValid && isPacked && packedHalf && packedMode == MSLU_IMMEDIATE
    && !packedImmUnsigned && !packedSub
    |=> resultData[31:16] == 16'($past(srcA[31:16]) + $past(refImmHalf)))
    else $error("immediate not sign extended");

  ext_off_a: assert property (
    issueValid && !extOn |=> resultUnknown && !resultValid)
    else $error("custom op accepted while disabled");

  mac_ulow_a: assert property (
    macULowIssue |=> resultOut ##0 resultData == 32'($past(refMacUL) >> $past(shamt)))
    else $error("unsigned low accumulate shift wrong");

  mac_uhigh_a: assert property (
    macUHighIssue |=> resultOut ##0 resultData == 32'($past(refMacUH) >> $past(shamt)))
    else $error("unsigned high accumulate shift wrong");

  mac_slow_a: assert property (
    macSLowIssue
    |=> resultOut ##0 resultData == 32'($signed($past(refMacSL)) >>> $past(shamt)))
    else $error("signed low accumulate shift wrong");

  mac_shigh_a: assert property (
    macSHighIssue
    |=> resultOut ##0 resultData == 32'($signed($past(refMacSH)) >>> $past(shamt)))
    else $error("signed high accumulate shift wrong");

  mul_shigh_a: assert property (
    issueValid && isMulS && variant == 2'h1
    |=> resultData == 32'($signed($past(refMulSH)) >>> $past(shamt)))
    else $error("signed high multiply wrong");

  round_unsigned_a: assert property (
    issueValid && isMacU && variant == 2'h2 && shamt != 5'h0
    |=> resultData == 32'(($past(refMacUL) + (34'h1 << ($past(shamt) - 5'h1)))
                          >> $past(shamt)))
    else $error("unsigned rounding term wrong");

  round_signed_a: assert property (
    issueValid && isMacS && variant == 2'h3 && shamt != 5'h0
    |=> resultData == 32'(($signed($past(refMacSH)) + (34'sh1 <<< ($past(shamt) - 5'h1)))
                          >>> $past(shamt)))
    else $error("signed rounding term wrong");

  refused_zero_a: assert property (
    refusedIssue |=> unknownOut)
    else $error("refused word gave result");

  lane_bsub_a: assert property (
    issueValid && isPacked && !packedHalf && packedMode == MSLU_VECTOR && packedSub
    |=> resultData[7:0] == 8'($past(srcA[7:0]) - $past(srcB[7:0]))
        && resultData[31:24] == 8'($past(srcA[31:24]) - $past(srcB[31:24])))
    else $error("byte lane difference wrong");

  imm_zero_a: assert property (
    issueValid && isPacked && packedHalf && packedMode == MSLU_IMMEDIATE
    && packedImmUnsigned && !packedSub
    |=> resultData[15:0] == 16'($past(srcA[15:0]) + {10'h0, $past(packedImm)}))
    else $error("unsigned immediate not zero extended");

  half_scalar_a: assert property (
    issueValid && isPacked && packedHalf && packedMode == MSLU_SCALAR && !packedSub
    |=> resultData[31:16] == 16'($past(srcA[31:16]) + $past(srcB[15:0])))
    else $error("halfword scalar not replicated");

  byte_lane_a: assert property (
    issueValid && isPacked && !packedHalf && packedMode == MSLU_VECTOR && !packedSub
    |=> resultData[15:8] == 8'($past(srcA[15:8]) + $past(srcB[15:8]))
        && resultData[23:16] == 8'($past(srcA[23:16]) + $past(srcB[23:16])))
    else $error("byte lane position wrong");

  byte_imm_a: assert property (
    issueValid && isPacked && !packedHalf && packedMode == MSLU_IMMEDIATE
    && !packedImmUnsigned && !packedSub
    |=> resultData[23:16] == 8'($past(srcA[23:16]) + $past(refImmHalf[7:0])))
    else $error("byte immediate not replicated");

  ext_off_mac_a: assert property (
    issueValid && !extOn && !packedOp |=> resultUnknown && !resultValid)
    else $error("multiply accumulate accepted while disabled");

endmodule

// [mslu_rf_model.sv]
// Destination register model with writeback forwarding
`timescale 1ns/1ps
module mslu_rf_model
  import mslu_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Preload from bench
  input  wire logic        loadEn,
  input  wire logic [31:0] loadValue,
  // Writeback from unit
  input  wire logic        resultValid,
  input  wire logic [31:0] resultData,
  // Third operand to unit
  output logic      [31:0] srcDest
);
  logic [31:0] destReg;

  assign srcDest = loadEn ? loadValue : (resultValid ? resultData : destReg);

  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      destReg <= RESULT_RST;
    else if (loadEn)
      destReg <= loadValue;
    else if (resultValid)
      destReg <= resultData;
endmodule

// [tb_mslu_unit.sv]
// Self-checking bench for the MAC and packed-lane unit
`timescale 1ns/1ps
module tb_mslu_unit;
  import mslu_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        issueValid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic        packedOp = 1'b0;
  logic        packedHalf = 1'b0;
  mslu_mode_t  packedMode = MSLU_VECTOR;
  logic [5:0]  packedImm = 6'h0;
  logic        packedImmUnsigned = 1'b0;
  logic        packedSub = 1'b0;
  logic [31:0] srcA = 32'h0;
  logic [31:0] srcB = 32'h0;
  logic        loadEn = 1'b0;
  logic [31:0] loadValue = 32'h0;
  logic [31:0] srcDest, resultData, w, e1;
  logic        resultValid, resultUnknown, offValid, offUnknown;
  logic [31:0] rows [4][4];
  logic [31:0] bad [4];
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;

  mslu_unit mslu_unit_inst (.clock, .rst_b, .issueValid, .instr, .packedOp, .packedHalf,
    .packedMode, .packedImm, .packedImmUnsigned, .packedSub, .srcA, .srcB, .srcDest,
    .resultValid, .resultData, .resultUnknown);
  mslu_unit #(.CUSTOM_EXT_ENABLE(1'b0)) mslu_unit_off_inst (.clock, .rst_b, .issueValid,
    .instr, .packedOp, .packedHalf, .packedMode, .packedImm, .packedImmUnsigned, .packedSub,
    .srcA, .srcB, .srcDest, .resultValid(offValid), .resultData(), .resultUnknown(offUnknown));
  mslu_rf_model mslu_rf_model_inst (.clock, .rst_b, .loadEn, .loadValue, .resultValid,
    .resultData, .srcDest);

  always #12.5 clock = ~clock;

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chkD(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkF(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic issue(logic [31:0] wd, logic [31:0] a, logic [31:0] b, logic [31:0] d,
                       logic ld);
    issueValid = 1'b1;
    packedOp = 1'b0;
    instr = wd;
    srcA = a;
    srcB = b;
    loadEn = ld;
    loadValue = d;
    @(posedge clock);
    #2;
  endtask

  function automatic logic [31:0] expHalf(logic [31:0] wd, a, b, d);
    logic sgn;
    logic [4:0] sh;
    logic [15:0] x, y;
    logic signed [33:0] s;
    sgn = !wd[12];
    sh = wd[29:25];
    x = wd[30] ? a[31:16] : a[15:0];
    y = wd[30] ? b[31:16] : b[15:0];
    s = $signed({{18{sgn & x[15]}}, x}) * $signed({{18{sgn & y[15]}}, y});
    if (wd[13])
      s = s + $signed({{2{sgn & d[31]}}, d});
    if (wd[31] && sh != 5'h0)
      s = s + (34'sh1 <<< (sh - 5'h1));
    return sgn ? 32'(s >>> sh) : 32'(s >> sh);
  endfunction

  function automatic logic [31:0] expLane(logic hw, logic [1:0] m, logic [5:0] im, logic iu,
                                          logic sb, logic [31:0] a, logic [31:0] b);
    logic [15:0] e;
    logic [31:0] op, r;
    e = {{10{im[5] & !iu}}, im};
    op = hw ? {2{e}} : {4{e[7:0]}};
    if (m == 2'h0)
      op = b;
    if (m == 2'h1)
      op = hw ? {2{b[15:0]}} : {4{b[7:0]}};
    for (int i = 0; i < 4; i++)
      r[8*i+:8] = sb ? a[8*i+:8] - op[8*i+:8] : a[8*i+:8] + op[8*i+:8];
    if (hw)
      for (int i = 0; i < 2; i++)
        r[16*i+:16] = sb ? a[16*i+:16] - op[16*i+:16] : a[16*i+:16] + op[16*i+:16];
    return r;
  endfunction

  initial
  begin
    rows = '{'{32'h8001_7fff, 32'hffff_8000, 32'h8000_0001, 32'h0},
             '{32'h1234_fffe, 32'hfedc_0003, 32'h0000_0010, 32'h5},
             '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h1f},
             '{32'h7fff_0101, 32'h8000_0202, 32'h4000_0000, 32'h1}};
    bad = '{{17'h10, 3'h2, 5'h3, OPC_HALF}, {F7_FULL_SUB + 7'h1, 10'h41, F3_FULL, 5'h3,
            OPC_FULL}, {F7_FULL_ACC, 10'h41, 3'h0, 5'h3, OPC_FULL}, 32'h0000_01b3};
    repeat (2) @(posedge clock);
    #2;
    chkF("valid in reset", 1'b0, resultValid);
    chkD("data in reset", RESULT_RST, resultData);
    rst_b = 1'b1;
    // ----------------------------------------------------------------
    // Row-driven half-word and full-width forms, back to back
    // ----------------------------------------------------------------
    foreach (rows[r])
    begin
      for (int f = 0; f < 16; f++)
      begin
        w = {f[1:0], rows[r][3][4:0], 10'h41, 1'b1, f[3:2], 5'h3, OPC_HALF};
        issue(w, rows[r][0], rows[r][1], rows[r][2], 1'b1);
        chkF("half valid", 1'b1, resultValid);
        e1 = expHalf(w, rows[r][0], rows[r][1], rows[r][2]);
        chkD("half data", e1, resultData);
        chkF("disabled unit", 1'b1, offUnknown);
        chkF("disabled valid", 1'b0, offValid);
      end
      for (int s = 0; s < 2; s++)
      begin
        w = {s[0] ? F7_FULL_SUB : F7_FULL_ACC, 10'h41, F3_FULL, 5'h3, OPC_FULL};
        issue(w, rows[r][0], rows[r][1], rows[r][2], 1'b1);
        chkF("full valid", 1'b1, resultValid);
        chkD("full data", s[0] ? rows[r][2] - rows[r][0] * rows[r][1]
             : rows[r][2] + rows[r][0] * rows[r][1], resultData);
      end
    end
    for (int k = 0; k < 24; k++)
    begin
      packedOp = 1'b1;
      packedHalf = k[0];
      packedSub = k[1];
      packedImmUnsigned = k[2];
      packedMode = mslu_mode_t'(k[4:3]);
      packedImm = 6'h2a;
      srcA = 32'h80ff_7f01;
      srcB = 32'h01ff_8081;
      loadEn = 1'b0;
      @(posedge clock);
      #2;
      chkF("lane valid", 1'b1, resultValid);
      chkD("lane data", expLane(k[0], k[4:3], 6'h2a, k[2], k[1], 32'h80ff_7f01,
           32'h01ff_8081), resultData);
      chkF("lane disabled", 1'b1, offUnknown);
      chkF("lane disabled valid", 1'b0, offValid);
    end
    // ----------------------------------------------------------------
    // Chained accumulate, idle hold, refusals, reset in mid-run
    // ----------------------------------------------------------------
    w = {2'h0, 5'h0, 10'h41, F3_MAC_U, 5'h3, OPC_HALF};
    issue(w, 32'h3, 32'h5, 32'h7, 1'b1);
    e1 = expHalf(w, 32'h3, 32'h5, 32'h7);
    issue(w, 32'h2, 32'h4, 32'h0, 1'b0);
    chkD("chained data", expHalf(w, 32'h2, 32'h4, e1), resultData);
    issueValid = 1'b0;
    @(posedge clock);
    #2;
    chkF("idle valid", 1'b0, resultValid);
    chkD("idle hold", expHalf(w, 32'h2, 32'h4, e1), resultData);
    foreach (bad[i])
    begin
      issue(bad[i], 32'h1234_5678, 32'h9abc_def0, 32'h1, 1'b1);
      chkF("refused flag", 1'b1, resultUnknown);
      chkF("refused valid", 1'b0, resultValid);
      chkD("refused data", 32'h0, resultData);
    end
    rst_b = 1'b0;
    #2;
    chkF("valid mid reset", 1'b0, resultValid);
    chkF("unknown mid reset", 1'b0, resultUnknown);
    chkD("data mid reset", RESULT_RST, resultData);
    @(posedge clock);
    #2;
    rst_b = 1'b1;
    issue(w, 32'h3, 32'h5, 32'h7, 1'b1);
    chkF("valid after reset", 1'b1, resultValid);
    chkD("data after reset", expHalf(w, 32'h3, 32'h5, 32'h7), resultData);
    results();
  end
endmodule
